// [dac_ctrl.sv]
// Purpose: Digital control of a two-channel 12-bit converter
// Assumes: AXI4-Lite slave, single clock, triggers asynchronous
// Notes: Analog core sees code, strobe and power controls
`timescale 1ns/100ps
`default_nettype none
module dac_ctrl
  import dac_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trigger_pin,
  input wire logic [2:0] timer_trig,
  input wire logic [1:0] pwm_event,
  output logic [11:0] dac_code,
  output logic [1:0] dac_load,
  output logic core_on,
  output logic ref_on,
  output logic [1:0] bias_ctl,
  output logic irq
);
  ////////////////////////////////////////////////////////////
  // State
  logic aw_held, w_held, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [31:0] mode_config, bias_reg;
  logic [1:0] chan_en;
  logic [1:0] irq_mask;
  logic eoc_flag, lock_en, lock_viol;
  logic [7:0] lock_src;
  logic [15:0] fifo [fifo_depth];
  logic [1:0] rd_ptr, wr_ptr;
  logic [2:0] count;
  conv_state_t state;
  logic [11:0] timer;
  logic [10:0] refresh_cnt;
  logic refresh_ch;
  logic [5:0] trig_s1, trig_s2, trig_s3;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0] next_awaddr;
  logic [31:0] next_wdata, next_rdata, next_mode, next_bias;
  logic [1:0] next_chan_en, next_irq_mask, next_rd_ptr, next_wr_ptr, next_load;
  logic next_eoc, next_lock_en, next_lock_viol, next_core_on, next_ref_on;
  logic [7:0] next_lock_src;
  logic [2:0] next_count;
  conv_state_t next_state;
  logic [11:0] next_timer, next_code;
  logic [10:0] next_refresh_cnt;
  logic next_refresh_ch;
  logic [15:0] next_fifo [fifo_depth];
  logic do_write, do_read, soft_rst, data_wr, pop, trig_edge, fifo_accept_flag, tag_sel;
  logic [1:0] push_n;
  logic [5:0] trig_raw;
  logic [15:0] head;
  logic [31:0] isr_val;
  logic [11:0] startup_cycles;

  ////////////////////////////////////////////////////////////
  // Combinational helpers
  // trigger source
  assign trig_raw = {pwm_event, timer_trig, ext_trigger_pin};
  assign do_write = aw_held && w_held && !bvalid_q;
  assign do_read = s_axi_arvalid && !rvalid_q;
  assign soft_rst = do_write && awaddr_q == off_control_command && wdata_q[0];
  assign data_wr = do_write && awaddr_q == off_conversion_data;
  assign push_n = mode_config[mr_word] ? 2'd2 : 2'd1;
  assign fifo_accept_flag = (chan_en != 2'b00) && (count <= 3'(fifo_depth) - 3'(push_n));
  assign head = fifo[rd_ptr];
  assign isr_val = {30'h0, eoc_flag, fifo_accept_flag};
  assign irq = |(irq_mask & {eoc_flag, fifo_accept_flag});
  assign startup_cycles = mode_config[mr_quick_wake_bit] ?
      12'((startup_step * clk_div) / fast_wake_div) : 12'(startup_step * clk_div);
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = 2'b00;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = 2'b00;
  assign bias_ctl = bias_reg[1:0];
  assign trig_edge = trig_s2[mode_config[mr_trigger_source_sel_lo +: 3]] && !trig_s3[mode_config[mr_trigger_source_sel_lo +: 3]];
  assign tag_sel = mode_config[mr_tag];

  ////////////////////////////////////////////////////////////
  // Bus and registers
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr = awaddr_q;
    next_wdata = wdata_q;
    next_bvalid = bvalid_q;
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_mode = mode_config;
    next_bias = bias_reg;
    next_chan_en = chan_en;
    next_irq_mask = irq_mask;
    next_eoc = eoc_flag;
    next_lock_en = lock_en;
    next_lock_viol = lock_viol;
    next_lock_src = lock_src;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata;
    end
    if (bvalid_q && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      unique case (s_axi_araddr)
        off_mode_config: next_rdata = mode_config;
        off_channel_enable_state: next_rdata = {30'h0, chan_en};
        off_irq_mask_state: next_rdata = {30'h0, irq_mask};
        off_irq_flags: begin
          next_rdata = isr_val;
          next_eoc = 1'b0;
        end
        off_analog_bias_current: next_rdata = bias_reg;
        off_write_lock_mode: next_rdata = {31'h0, lock_en};
        off_write_lock_status: begin
          next_rdata = {8'h0, 8'h0, lock_src, 7'h0, lock_viol};
          next_lock_viol = 1'b0;
        end
        default: next_rdata = 32'h00000000;
      endcase
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (lock_en && (awaddr_q == off_mode_config || awaddr_q == off_channel_enable_set ||
          awaddr_q == off_channel_enable_clear || awaddr_q == off_analog_bias_current)) begin
        next_lock_viol = 1'b1;
        next_lock_src = awaddr_q;
      end else begin
        unique case (awaddr_q)
          off_mode_config: next_mode = wdata_q & write_mask_mode;
          off_channel_enable_set: next_chan_en = chan_en | wdata_q[1:0];
          off_channel_enable_clear: next_chan_en = chan_en & ~wdata_q[1:0];
          off_irq_mask_set: next_irq_mask = irq_mask | wdata_q[1:0];
          off_irq_mask_clear: next_irq_mask = irq_mask & ~wdata_q[1:0];
          off_analog_bias_current: next_bias = wdata_q & write_mask_bias;
          off_write_lock_mode: begin
            if (wdata_q[31:8] == lock_key) begin
              next_lock_en = wdata_q[0];
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (state == st_convert && timer == 12'd1) begin
      next_eoc = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // FIFO and conversion sequencer
  always_comb begin
    next_fifo = fifo;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    next_state = state;
    next_timer = timer;
    next_code = dac_code;
    next_load = 2'b00;
    next_core_on = core_on;
    next_ref_on = ref_on;
    next_refresh_cnt = refresh_cnt;
    next_refresh_ch = refresh_ch;
    pop = 1'b0;
    if (data_wr && count <= 3'(fifo_depth) - 3'(push_n)) begin
      next_fifo[wr_ptr] = wdata_q[15:0];
      if (mode_config[mr_word]) begin
        next_fifo[2'(wr_ptr + 2'd1)] = wdata_q[31:16];
      end
      next_wr_ptr = 2'(wr_ptr + push_n);
    end
    unique case (state)
      st_off: begin
        next_core_on = 1'b0;
        next_ref_on = ref_on && mode_config[mr_quick_wake_bit];
        if (count != 3'd0 && chan_en != 2'b00) begin
          next_state = st_wake;
          next_timer = startup_cycles;
          next_core_on = 1'b1;
          next_ref_on = 1'b1;
        end
      end
      st_wake: begin
        next_timer = timer - 12'd1;
        if (timer <= 12'd1) begin
          next_state = st_idle;
        end
      end
      st_idle: begin
        if (count != 3'd0) begin
          next_state = mode_config[mr_ext_trigger_on] ? st_wait_trig : st_convert;
          next_timer = mode_config[mr_max_rate_mode] ? max_rate_mode_cycles : conv_cycles;
        end else if (mode_config[mr_sleep]) begin
          next_state = st_off;
          next_core_on = 1'b0;
          next_ref_on = mode_config[mr_quick_wake_bit];
        end
      end
      st_wait_trig: begin
        if (!mode_config[mr_ext_trigger_on] || trig_edge) begin
          next_state = st_convert;
        end
      end
      st_convert: begin
        next_timer = timer - 12'd1;
        if (timer == 12'd1) begin
          pop = 1'b1;
          next_rd_ptr = 2'(rd_ptr + 2'd1);
          next_code = head[11:0];
          next_load = 2'b01 << (tag_sel ? head[12] : mode_config[mr_user_sel_lo]);
          next_state = st_idle;
        end
      end
      default: next_state = st_off;
    endcase
    next_count = 3'(count + ((data_wr && count <= 3'(fifo_depth) - 3'(push_n)) ? {1'b0, push_n} : 3'd0)
        - (pop ? 3'd1 : 3'd0));
    if (mode_config[mr_refresh_lo +: 8] == 8'h01 && state != st_off) begin
      next_refresh_cnt = refresh_cnt + 11'd1;
      if (refresh_cnt == refresh_cycles - 11'd1) begin
        next_refresh_cnt = 11'd0;
        next_refresh_ch = !refresh_ch;
        if (next_load == 2'b00) begin
          next_load = chan_en & (2'b01 << refresh_ch);
        end
      end
    end else begin
      next_refresh_cnt = 11'd0;
    end
    if (chan_en == 2'b00) begin
      next_state = st_off;
      next_core_on = 1'b0;
      next_ref_on = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk) begin
    trig_s1 <= trig_raw;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      bvalid_q <= next_bvalid;
      rvalid_q <= next_rvalid;
      awaddr_q <= next_awaddr;
      wdata_q <= next_wdata;
      rdata_q <= next_rdata;
    end
    if (!aresetn || soft_rst) begin
      mode_config <= mode_reset;
      bias_reg <= 32'h00000000;
      chan_en <= 2'b00;
      irq_mask <= 2'b00;
      eoc_flag <= 1'b0;
      lock_en <= 1'b0;
      lock_viol <= 1'b0;
      lock_src <= 8'h00;
      rd_ptr <= 2'b00;
      wr_ptr <= 2'b00;
      count <= 3'd0;
      state <= st_off;
      timer <= 12'h000;
      dac_code <= 12'h000;
      dac_load <= 2'b00;
      core_on <= 1'b0;
      ref_on <= 1'b0;
      refresh_cnt <= 11'h000;
      refresh_ch <= 1'b0;
      for (int i = 0; i < fifo_depth; i++) begin
        fifo[i] <= 16'h0000;
      end
    end else begin
      mode_config <= next_mode;
      bias_reg <= next_bias;
      chan_en <= next_chan_en;
      irq_mask <= next_irq_mask;
      eoc_flag <= next_eoc;
      lock_en <= next_lock_en;
      lock_viol <= next_lock_viol;
      lock_src <= next_lock_src;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      state <= next_state;
      timer <= next_timer;
      dac_code <= next_code;
      dac_load <= next_load;
      core_on <= next_core_on;
      ref_on <= next_ref_on;
      refresh_cnt <= next_refresh_cnt;
      refresh_ch <= next_refresh_ch;
      fifo <= next_fifo;
    end
  end
endmodule : dac_ctrl
`default_nettype wire

// [dac_ctrl_pkg.sv]
// Purpose: Constants for the two-channel converter controller
// Assumes: 100 MHz aclk, AXI4-Lite with 32-bit data
// Notes: Offsets are byte addresses
package dac_ctrl_pkg;
  localparam logic [7:0] off_control_command = 8'h00;
  localparam logic [7:0] off_mode_config = 8'h04;
  localparam logic [7:0] off_channel_enable_set = 8'h10;
  localparam logic [7:0] off_channel_enable_clear = 8'h14;
  localparam logic [7:0] off_channel_enable_state = 8'h18;
  localparam logic [7:0] off_conversion_data = 8'h20;
  localparam logic [7:0] off_irq_mask_set = 8'h24;
  localparam logic [7:0] off_irq_mask_clear = 8'h28;
  localparam logic [7:0] off_irq_mask_state = 8'h2c;
  localparam logic [7:0] off_irq_flags = 8'h30;
  localparam logic [7:0] off_analog_bias_current = 8'h94;
  localparam logic [7:0] off_write_lock_mode = 8'he4;
  localparam logic [7:0] off_write_lock_status = 8'he8;
  // Mode field positions
  localparam int mr_ext_trigger_on = 0;
  localparam int mr_trigger_source_sel_lo = 1;
  localparam int mr_word = 4;
  localparam int mr_sleep = 5;
  localparam int mr_quick_wake_bit = 6;
  localparam int mr_refresh_lo = 8;
  localparam int mr_user_sel_lo = 16;
  localparam int mr_tag = 20;
  localparam int mr_max_rate_mode = 21;
  localparam int mr_startup_lo = 24;
  // Status bits
  localparam int isr_fifo_accept_flag = 0;
  localparam int isr_eoc = 1;
  localparam logic [31:0] mode_reset = 32'h00000000;
  localparam logic [31:0] write_mask_mode = 32'h3f33ff7f;
  localparam logic [31:0] write_mask_bias = 32'h00000303;
  localparam logic [23:0] lock_key = 24'h444143;
  // Timing in conversion-clock periods, except refresh_mck, which counts aclk cycles
  localparam int conv_periods = 25;
  localparam int max_rate_mode_saving = 2;
  localparam int clk_div = 2;
  localparam logic [11:0] conv_cycles = 12'(conv_periods * clk_div);
  localparam logic [11:0] max_rate_mode_cycles = 12'((conv_periods - max_rate_mode_saving) * clk_div);
  localparam int refresh_mck = 1024;
  localparam logic [10:0] refresh_cycles = 11'(refresh_mck);
  localparam int startup_step = 64;
  localparam int fast_wake_div = 4;
  localparam int fifo_depth = 4;
  typedef enum logic [2:0] {
    st_off = 3'b000,
    st_idle = 3'b001,
    st_wake = 3'b010,
    st_wait_trig = 3'b011,
    st_convert = 3'b100
  } conv_state_t;
endpackage : dac_ctrl_pkg

// [dac_ctrl_checker.sv]
// Purpose: Port assertions for dac_ctrl
// Assumes: One aclk domain, sync low reset
// Notes: Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module dac_ctrl_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] dac_load,
  input wire logic core_on,
  input wire logic [1:0] bias_ctl,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  ////////////////////////////////////////
  a_write_answer: assert property (wr_go |=> ##1 (s_axi_bvalid && s_axi_bresp == 2'b00))
    else $error("write answer late");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held");
  a_load_pulse: assert property (dac_load != 2'b00 |=> dac_load == 2'b00)
    else $error("load not a pulse");
  a_load_single: assert property ($onehot0(dac_load))
    else $error("two channels loaded");
  a_load_powered: assert property (dac_load != 2'b00 |-> core_on || $past(core_on))
    else $error("load while core off");
  a_soft_reset: assert property (wr_go && s_axi_awaddr == 8'h00 && s_axi_wdata[0]
    |-> ##[1:4] (!core_on && bias_ctl == 2'b00 && !irq))
    else $error("soft reset ignored");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && dac_load == 2'b00 && !core_on)
    else $error("outputs busy after reset");
  c_load0: cover property (dac_load[0]);
  c_load1: cover property (dac_load[1]);
  c_irq: cover property (irq);
endmodule : dac_ctrl_checker
`default_nettype wire

// [dac_core_model.sv]
// Purpose: Analog core and trigger sources
// Assumes: Triggers idle low between pulses
// Notes: fire gives one rising edge
`timescale 1ns/100ps
`default_nettype none
module dac_core_model (
  input wire logic aclk,
  input wire logic [11:0] dac_code,
  input wire logic [1:0] dac_load,
  input wire logic core_on,
  output logic ext_trigger_pin,
  output logic [2:0] timer_trig,
  output logic [1:0] pwm_event
);
  logic [11:0] level [2];
  initial begin
    {pwm_event, timer_trig, ext_trigger_pin} = 6'h00;
  end
  always @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      if (dac_load[c] && core_on) level[c] <= dac_code;
    end
  end
  task automatic fire(input int src, input int len);
    @(posedge aclk);
    {pwm_event, timer_trig, ext_trigger_pin} <= 6'h01 << src;
    repeat (len) @(posedge aclk);
    {pwm_event, timer_trig, ext_trigger_pin} <= 6'h00;
  endtask : fire
endmodule : dac_core_model
`default_nettype wire

// [test_dac_ctrl.sv]
// Purpose: Register-level bench for dac_ctrl
// Assumes: AXI4-Lite master tasks, core model
// Notes: Timing from package constants
`timescale 1ns/100ps
`default_nettype none
module test_dac_ctrl
  import dac_ctrl_pkg::*;
;
  localparam int wake_full = startup_step * clk_div;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, core_on, ref_on;
  logic ext_trigger_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, dac_load, bias_ctl, pwm_event;
  logic [11:0] dac_code;
  logic [2:0] timer_trig;
  logic [13:0] g;
  logic [7:0] regs [8] = '{8'h04, 8'h08, 8'h18, 8'h2c, 8'h30, 8'h94, 8'he4, 8'he8};
  int failures = 0, samples_checked = 0, t, t1;
  dac_ctrl u_dac_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger_pin, .timer_trig,
    .pwm_event, .dac_code, .dac_load, .core_on, .ref_on, .bias_ctl, .irq);
  dac_core_model u_dac_core_model (.aclk, .dac_code, .dac_load, .core_on, .ext_trigger_pin, .timer_trig, .pwm_event);
  initial begin
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic hang;
    failures++;
    $display("ERROR %0t wait timed out", $time);
    finish_test();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    if (!done) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (!done) hang();
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, r);
    chk(r, e);
  endtask : rc
  task automatic wl(input int lim, input bit need);
    for (t = 0; t < lim; t++) begin
      @(posedge aclk);
      if (dac_load !== 2'b00) break;
    end
    g = {dac_load, dac_code};
    if (need && t == lim) hang();
  endtask : wl
  task automatic cv(input logic [31:0] d, input logic [13:0] e);
    wr(8'h20, d);
    wl(600, 1'b1);
    chk(32'(g), 32'(e));
  endtask : cv
  task automatic idle;
    int n;
    for (n = 0; n < 300 && core_on !== 1'b0; n++) @(posedge aclk);
    chk(32'(core_on), 32'h0);
    if (n == 300) hang();
  endtask : idle
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rc(regs[i], 32'h0);
    wr(8'h94, 32'hffffffff);
    rc(8'h94, write_mask_bias);
    chk(32'(bias_ctl), 32'h3);
    wr(8'h10, 32'h1);
    rc(8'h18, 32'h1);
    rc(8'h30, 32'h1);
    wr(8'h24, 32'h1);
    chk(32'(irq), 32'h1);
    rc(8'h2c, 32'h1);
    wr(8'h28, 32'h1);
    chk(32'(irq), 32'h0);
    wr(8'h04, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rc(8'h30, 32'h1);
      wr(8'h20, 32'h5a5af100 + i);
    end
    rc(8'h30, 32'h0);
    wl(100, 1'b0);
    chk(t, 100);
    for (int i = 0; i < 6; i++) begin
      if (i > 3) wr(8'h20, 32'h100 + i);
      wr(8'h04, 32'h1 + (i << 1));
      u_dac_core_model.fire(i, 3 + 10 * (i % 2));
      wl(600, 1'b1);
      chk(32'(g), 32'h1100 + i);
    end
    rc(8'h30, 32'h3);
    chk(32'(u_dac_core_model.level[0]), 32'h105);
    rc(8'h30, 32'h1);
    wr(8'h20, 32'h0777);
    wr(8'h04, 32'h0);
    wl(600, 1'b1);
    chk(32'(g), 32'h1777);
    wr(8'h10, 32'h3);
    wr(8'h04, 32'h00100010);
    cv(32'h04561123, 14'h2123);
    wl(600, 1'b1);
    chk(32'(g), 32'h1456);
    chk(t, 32'(conv_cycles));
    wr(8'h04, 32'h00200010);
    cv(32'h02221111, 14'h1111);
    wl(600, 1'b1);
    chk(t, 32'(max_rate_mode_cycles));
    wr(8'h04, 32'h100);
    wl(1100, 1'b1);
    wl(1100, 1'b1);
    chk(t + 1, 32'(refresh_cycles));
    wr(8'h04, 32'h0);
    wl(1200, 1'b0);
    chk(t, 1200);
    wr(8'h04, 32'h20);
    idle();
    cv(32'h0333, 14'h1333);
    t1 = t;
    wr(8'h04, 32'h04000060);
    cv(32'h0444, 14'h1444);
    idle();
    chk(32'(ref_on), 32'h1);
    cv(32'h0555, 14'h1555);
    chk(t1 - t, wake_full - wake_full / fast_wake_div);
    wr(8'h04, 32'h0);
    wr(8'he4, {lock_key, 8'h01});
    wr(8'h04, 32'h1);
    rc(8'h04, 32'h0);
    wr(8'h14, 32'h3);
    rc(8'h18, 32'h3);
    rc(8'he8, 32'h1401);
    rd(8'he8, r);
    chk(32'(r[0]), 32'h0);
    wr(8'he4, {lock_key, 8'h00});
    cv(32'h0666, 14'h1666);
    chk(32'(core_on), 32'h1);
    wr(8'h14, 32'h3);
    idle();
    rc(8'h30, 32'h2);
    wr(8'h04, 32'h10000);
    wr(8'h00, 32'h0);
    rc(8'h04, 32'h10000);
    wr(8'h00, 32'h1);
    rc(8'h04, 32'h0);
    finish_test();
  end
endmodule : test_dac_ctrl
bind dac_ctrl dac_ctrl_checker u_dac_ctrl_checker (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .dac_load, .core_on, .bias_ctl, .irq);
`default_nettype wire
